// File: bench/isu_checker.sv
`timescale 1ns/1ps
`default_nettype none
module isu_checker
  import isu_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata
);
  logic dp, dw, ovr, ca0;
  logic [7:0] da;
  logic [5:0] amt;
  logic [31:0] src, ovv;
  // Shadows the data phase and what a CTRL write consumes and yields, so the checks stay cheap
  wire rd = dp && !dw;
  wire fl = rd && da == ISU_OFS_FLAGS;
  wire wc = dp && dw && hready && hce;
  wire wo = wc && da == ISU_OFS_CTRL && hwdata[1:0] != 2'h3;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      dp <= 1'b0;
      ovr <= 1'b0;
      ca0 <= 1'b1;
    end
    else
    begin
      if (hce && hready) dp <= hsel && htrans[1];
      if (hce && hready) dw <= hwrite;
      if (hce && hready) da <= haddr[7:0];
      if (wc && da == ISU_OFS_SRC) src <= hwdata;
      if (wc && da == ISU_OFS_AMT) amt <= hwdata[5:0];
      if (wo) ovr <= amt[5];
      if (wo) ovv <= (hwdata[1:0] == 2'h0) ? {32{src[31]}} : 32'h0;
      if (wo && hwdata[1:0] == 2'h0) ca0 <= amt == 6'h0 || !src[31];
    end
  property p_rdy; hreadyout == hce; endproperty
  a_rdy: assert property (p_rdy) else $error("ready differs from enable");
  property p_ok; hresp == 1'b0; endproperty
  a_ok: assert property (p_ok) else $error("response not okay");
  property p_idle; !rd |-> hrdata == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("read data outside read");
  property p_unmap; rd && da > ISU_OFS_FLAGS |-> hrdata == 32'h0; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_so; fl |-> !hrdata[4]; endproperty
  a_so: assert property (p_so) else $error("summary bit set");
  property p_cc; fl |-> $onehot0(hrdata[7:5]); endproperty
  a_cc: assert property (p_cc) else $error("condition not exclusive");
  property p_ovr; rd && da == ISU_OFS_DEST && ovr |-> hrdata == ovv; endproperty
  a_ovr: assert property (p_ovr) else $error("overshift result wrong");
  property p_ca0; fl && ca0 |-> !hrdata[0]; endproperty
  a_ca0: assert property (p_ca0) else $error("carry not clear");
endmodule
bind isu_shift_unit isu_checker chk (.hclk(hclk), .hresetn(hresetn), .hce(hce), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));
`default_nettype wire

// File: bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench
  import isu_pkg::*;
;
  logic hclk = 1'b0, hresetn = 1'b0, hce = 1'b1, hwrite = 1'b0, m_ca = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [3:0] m_cr = 4'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, m_dest = 32'h0, m_aux = 32'h0, q;
  wire logic hready, hresp;
  wire logic [31:0] hrdata;
  int mismatches = 0, n_compared = 0;
  always #4 hclk = ~hclk;
  isu_shift_unit DUT (.hclk(hclk), .hresetn(hresetn), .hce(hce), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hready), .hresp(hresp), .hrdata(hrdata));
  task automatic finish_test();
    $display("mismatches %0d compared %0d", mismatches, n_compared);
    if (mismatches == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e)
    begin
      mismatches++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wt();
    int i;
    i = 0;
    do
    begin
      @(posedge hclk);
      i++;
    end
    while (hready !== 1'b1 && i < 50);
    if (i >= 50) mismatches++;
    if (i >= 50) finish_test();
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    hwrite <= w;
    haddr <= {24'h0, a};
    htrans <= ISU_HTRANS_NONSEQ;
    wt();
    htrans <= 2'h0;
    hwdata <= d;
    wt();
    q = hrdata;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  // Model of the datapath; the sign-fill shift needs its own signed variable
  task automatic op(input logic [31:0] s, input logic [5:0] a, input logic [2:0] c);
    logic [63:0] t;
    logic [31:0] rl, rr, d;
    logic signed [31:0] sa;
    t = {s, s} << a[4:0];
    rl = t[63:32];
    t = {s, s} << (6'd32 - a[4:0]);
    rr = t[63:32];
    sa = $signed(s) >>> a[4:0];
    case (c[1:0])
      2'h0: d = a[5] ? {32{s[31]}} : sa;
      2'h1: d = a[5] ? 32'h0 : rl & (32'hFFFF_FFFF << a[4:0]);
      2'h2: d = a[5] ? 32'h0 : rr & (32'hFFFF_FFFF >> a[4:0]);
      default: d = m_dest;
    endcase
    if (c[1:0] == 2'h0) m_ca = s[31] & (a[5] | (|(s & ~(32'hFFFF_FFFF << a[4:0]))));
    if (c[1:0] == 2'h1) m_aux = rl;
    if (c[1:0] == 2'h2) m_aux = rr;
    if (c[2] && c[1:0] != 2'h3) m_cr = {d[31], !d[31] && d != 32'h0, d == 32'h0, 1'b0};
    m_dest = d;
    xfer(1'b1, ISU_OFS_SRC, s);
    xfer(1'b1, ISU_OFS_AMT, {26'h0, a});
    xfer(1'b1, ISU_OFS_CTRL, {29'h0, c});
    rd(ISU_OFS_DEST, m_dest);
    rd(ISU_OFS_AUX, m_aux);
    rd(ISU_OFS_FLAGS, {24'h0, m_cr, 3'h0, m_ca});
  endtask
  initial
  begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(ISU_OFS_CTRL, 32'h3);
    rd(ISU_OFS_FLAGS, 32'h0);
    rd(8'h40, 32'h0);
    xfer(1'b1, ISU_OFS_DEST, 32'hFFFF_FFFF);
    rd(ISU_OFS_DEST, 32'h0);
    m_aux = 32'hA5A5_0F0F;
    xfer(1'b1, ISU_OFS_AUX, m_aux);
    rd(ISU_OFS_AUX, m_aux);
    hce <= 1'b0;
    repeat (3) @(posedge hclk);
    chk({31'h0, hready}, 32'h0);
    hce <= 1'b1;
    rd(ISU_OFS_AUX, m_aux);
    op(32'h8000_00F1, 6'h04, 3'h4);
    op(32'h8000_0010, 6'h04, 3'h0);
    op(32'h8000_0000, 6'h20, 3'h4);
    op(32'h1234_5678, 6'h00, 3'h0);
    op(32'h7FFF_FFFF, 6'h1F, 3'h4);
    op(32'hF000_000F, 6'h04, 3'h5);
    op(32'h8123_4567, 6'h25, 3'h5);
    op(32'hF000_000F, 6'h08, 3'h6);
    op(32'h89AB_CDEF, 6'h00, 3'h2);
    op(32'h89AB_CDEF, 6'h3F, 3'h6);
    op(32'h0000_0000, 6'h01, 3'h7);
    finish_test();
  end
endmodule
`default_nettype wire

// File: verilog/isu_pkg.sv
package isu_pkg;

  localparam int unsigned ISU_DW = 32;
  localparam int unsigned ISU_AW = 8;

  // Register byte offsets
  localparam logic [ISU_AW-1:0] ISU_OFS_CTRL = 8'h00;
  localparam logic [ISU_AW-1:0] ISU_OFS_SRC = 8'h04;
  localparam logic [ISU_AW-1:0] ISU_OFS_AMT = 8'h08;
  localparam logic [ISU_AW-1:0] ISU_OFS_DEST = 8'h0C;
  localparam logic [ISU_AW-1:0] ISU_OFS_AUX = 8'h10;
  localparam logic [ISU_AW-1:0] ISU_OFS_FLAGS = 8'h14;

  // Control register fields
  localparam int unsigned ISU_CTRL_OP_LSB = 0;
  localparam int unsigned ISU_CTRL_OP_W = 2;
  localparam int unsigned ISU_CTRL_REC_BIT = 2;

  // Flags register fields
  localparam int unsigned ISU_FLAGS_CA_BIT = 0;
  localparam int unsigned ISU_FLAGS_CR_LSB = 4;
  localparam int unsigned ISU_CR_W = 4;

  // Amount register fields, little-endian view of big-endian bits 26 and 27-31
  localparam int unsigned ISU_AMT_N_LSB = 0;
  localparam int unsigned ISU_AMT_N_W = 5;
  localparam int unsigned ISU_AMT_OVER_BIT = 5;

  // Condition field bit positions (lt, gt, eq, so from msb down)
  localparam int unsigned ISU_CR_LT = 3;
  localparam int unsigned ISU_CR_GT = 2;
  localparam int unsigned ISU_CR_EQ = 1;
  localparam int unsigned ISU_CR_SO = 0;

  // Reset values
  localparam logic [ISU_DW-1:0] ISU_RST_WORD = 32'h0000_0000;
  localparam logic [ISU_CR_W-1:0] ISU_RST_CR = 4'h0;
  localparam logic [2:0] ISU_RST_CTRL = 3'h3;

  // AHB encodings
  localparam logic [1:0] ISU_HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] ISU_HTRANS_SEQ = 2'h3;
  localparam logic [2:0] ISU_HSIZE_WORD = 3'h2;

  typedef enum logic [1:0] {
    ISU_OP_SRA = 2'b00,
    ISU_OP_SLQ = 2'b01,
    ISU_OP_SRQ = 2'b10,
    ISU_OP_NONE = 2'b11
  } isu_op_e;

endpackage

// File: verilog/isu_shift_unit.sv
// Our own choices: the AHB-Lite register port and the address map.
`timescale 1ns/1ps
`default_nettype none

module isu_shift_unit
  import isu_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata
);

  // Signed compare of a result word against zero
  function automatic logic [ISU_CR_W-1:0] cond_of(input logic [ISU_DW-1:0] w);
    logic [ISU_CR_W-1:0] c;
    c = '0;
    c[ISU_CR_LT] = w[ISU_DW-1];
    c[ISU_CR_GT] = ~w[ISU_DW-1] & (|w);
    c[ISU_CR_EQ] = ~(|w);
    c[ISU_CR_SO] = 1'b0;
    return c;
  endfunction

  function automatic logic [ISU_DW-1:0] rotl(input logic [ISU_DW-1:0] w,
                                              input logic [ISU_AMT_N_W-1:0] n);
    logic [2*ISU_DW-1:0] d;
    d = {w, w} << n;
    return d[2*ISU_DW-1:ISU_DW];
  endfunction

  // Register file
  logic [ISU_DW-1:0] source_register;
  logic [ISU_DW-1:0] amount_register;
  logic [ISU_DW-1:0] dest_register;
  logic [ISU_DW-1:0] aux_rotate_register;
  logic carry_flag;
  logic [ISU_CR_W-1:0] condition_field_zero;
  isu_op_e op_sel;
  logic record_form;

  // Bus address phase capture
  logic dph_wr;
  logic dph_rd;
  logic [ISU_AW-1:0] dph_addr;
  logic addr_valid;

  assign addr_valid = hsel & hready & (htrans == ISU_HTRANS_NONSEQ || htrans == ISU_HTRANS_SEQ);

  // Freezing the clock enable stalls the bus so no transfer is dropped
  assign hreadyout = hce;
  assign hresp = 1'b0;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dph_wr <= 1'b0;
      dph_rd <= 1'b0;
      dph_addr <= '0;
    end
    else if (hce)
    begin
      dph_wr <= addr_valid & hwrite & (hsize == ISU_HSIZE_WORD);
      dph_rd <= addr_valid & ~hwrite;
      dph_addr <= haddr[ISU_AW-1:0];
    end
  end

  logic wr_ctrl;
  logic wr_src;
  logic wr_amt;
  logic wr_aux;
  assign wr_ctrl = hce & dph_wr & (dph_addr == ISU_OFS_CTRL);
  assign wr_src = hce & dph_wr & (dph_addr == ISU_OFS_SRC);
  assign wr_amt = hce & dph_wr & (dph_addr == ISU_OFS_AMT);
  assign wr_aux = hce & dph_wr & (dph_addr == ISU_OFS_AUX);

  // Operation launched by a control write, using the operands stored now
  isu_op_e new_op;
  logic new_rec;
  assign new_op = isu_op_e'(hwdata[ISU_CTRL_OP_LSB +: ISU_CTRL_OP_W]);
  assign new_rec = hwdata[ISU_CTRL_REC_BIT];

  // Shift datapath
  logic [ISU_AMT_N_W-1:0] n;
  logic over;
  logic sign;
  logic [ISU_DW-1:0] sra_res;
  logic [ISU_DW-1:0] lost_mask;
  logic sra_ca;
  logic [ISU_DW-1:0] ones;
  logic [ISU_DW-1:0] slq_rot;
  logic [ISU_DW-1:0] srq_rot;
  logic [ISU_DW-1:0] slq_mask;
  logic [ISU_DW-1:0] srq_mask;

  assign n = amount_register[ISU_AMT_N_LSB +: ISU_AMT_N_W];
  assign over = amount_register[ISU_AMT_OVER_BIT];
  assign sign = source_register[ISU_DW-1];
  assign ones = {ISU_DW{1'b1}};

  always_comb
  begin
    if (over)
    begin
      sra_res = {ISU_DW{sign}};
      lost_mask = ones;
    end
    else
    begin
      sra_res = $signed(source_register) >>> n;
      lost_mask = ~(ones << n);
    end
  end

  // A zero amount loses no bits, so carry falls to zero on its own
  assign sra_ca = sign & (|(source_register & lost_mask));

  assign slq_rot = rotl(source_register, n);
  assign srq_rot = rotl(source_register, ISU_AMT_N_W'(ISU_DW - n));
  assign slq_mask = over ? '0 : (ones << n);
  assign srq_mask = over ? '0 : (ones >> n);

  logic [ISU_DW-1:0] next_dest;
  always_comb
  begin
    case (new_op)
      ISU_OP_SRA: next_dest = sra_res;
      ISU_OP_SLQ: next_dest = slq_rot & slq_mask;
      ISU_OP_SRQ: next_dest = srq_rot & srq_mask;
      default: next_dest = dest_register;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      source_register <= ISU_RST_WORD;
      amount_register <= ISU_RST_WORD;
    end
    else
    begin
      if (wr_src)
        source_register <= hwdata;
      if (wr_amt)
        amount_register <= hwdata;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      op_sel <= isu_op_e'(ISU_RST_CTRL[ISU_CTRL_OP_LSB +: ISU_CTRL_OP_W]);
      record_form <= ISU_RST_CTRL[ISU_CTRL_REC_BIT];
      dest_register <= ISU_RST_WORD;
    end
    else if (wr_ctrl)
    begin
      op_sel <= new_op;
      record_form <= new_rec;
      dest_register <= next_dest;
    end
  end

  // The operation write wins over a software write to the auxiliary register
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      aux_rotate_register <= ISU_RST_WORD;
    else if (wr_ctrl && new_op == ISU_OP_SLQ)
      aux_rotate_register <= slq_rot;
    else if (wr_ctrl && new_op == ISU_OP_SRQ)
      aux_rotate_register <= srq_rot;
    else if (wr_aux)
      aux_rotate_register <= hwdata;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      carry_flag <= 1'b0;
    else if (wr_ctrl && new_op == ISU_OP_SRA)
      carry_flag <= sra_ca;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      condition_field_zero <= ISU_RST_CR;
    else if (wr_ctrl && new_rec && new_op != ISU_OP_NONE)
      condition_field_zero <= cond_of(next_dest);
  end

  // Read mux of flop outputs; unmapped offsets read zero
  always_comb
  begin
    hrdata = '0;
    if (dph_rd)
    begin
      case (dph_addr)
        ISU_OFS_CTRL:
        begin
          hrdata[ISU_CTRL_OP_LSB +: ISU_CTRL_OP_W] = op_sel;
          hrdata[ISU_CTRL_REC_BIT] = record_form;
        end
        ISU_OFS_SRC: hrdata = source_register;
        ISU_OFS_AMT: hrdata = amount_register;
        ISU_OFS_DEST: hrdata = dest_register;
        ISU_OFS_AUX: hrdata = aux_rotate_register;
        ISU_OFS_FLAGS:
        begin
          hrdata[ISU_FLAGS_CA_BIT] = carry_flag;
          hrdata[ISU_FLAGS_CR_LSB +: ISU_CR_W] = condition_field_zero;
        end
        default: hrdata = '0;
      endcase
    end
  end

endmodule

`default_nettype wire
